/* core/prm_pkg.sv */
// Constants, register map and key-sequence states for the pin remap unit.
// Assumes a 16-bit register port and byte addresses that are multiples of four.
package prm_pkg;

    // ***************************************************************
    // Sizes
    // ***************************************************************
    localparam int unsigned PIN_COUNT = 26;  // Remappable pins on this variant
    localparam int unsigned IN_COUNT  = 8;   // Remappable peripheral inputs
    localparam int unsigned SEL_W     = 5;   // Width of every selection field
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 16;

    // ***************************************************************
    // Register map, byte addresses
    // ***************************************************************
    localparam logic [7:0] IN_BASE   = 8'h00;  // One word per peripheral input
    localparam logic [7:0] OUT_BASE  = 8'h40;  // One word per pin
    localparam logic [7:0] OSC_ADDR  = 8'hc0;  // Oscillator control, key and lock
    localparam logic [7:0] STAT_ADDR = 8'hc4;  // Read-only status
    localparam logic [7:0] OUT_END   = 8'ha8;  // OUT_BASE + 4 * PIN_COUNT

    // ***************************************************************
    // Fields and reset values
    // ***************************************************************
    localparam int unsigned LOCK_BIT   = 6;    // Lock bit in oscillator control
    localparam logic [4:0]  IN_SEL_RST = 5'h1f; // Unused pin number, input tied low
    localparam logic [4:0]  OUT_FN_RST = 5'h00;
    localparam logic [7:0]  KEY_FIRST  = 8'h46;
    localparam logic [7:0]  KEY_SECOND = 8'h57;

    // ***************************************************************
    // Output function codes
    // ***************************************************************
    localparam logic [4:0] FN_PORT     = 5'h00;
    localparam logic [4:0] FN_U1_TX    = 5'h03;
    localparam logic [4:0] FN_U1_RTS   = 5'h04;
    localparam logic [4:0] FN_SPI_DO   = 5'h07;
    localparam logic [4:0] FN_SPI_CLK  = 5'h08;
    localparam logic [4:0] FN_SPI_SEL  = 5'h09;
    localparam logic [4:0] FN_CMP1     = 5'h12;
    localparam logic [4:0] FN_CMP2     = 5'h13;

    // Unlock sequence progress
    typedef enum logic [1:0] {
        KEY_IDLE  = 2'b00,
        KEY_HALF  = 2'b01,
        KEY_ARMED = 2'b10
    } prm_key_e;

endpackage

/* core/prm_key_lock.sv */
// Write lock for the route registers, closed by a two-key sequence and, outside single-session mode, opened by one.
// Assumes osc_wr is a one-cycle strobe for a write to the oscillator control word.
`timescale 1ns/10ps
module prm_key_lock import prm_pkg::*; (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       osc_wr,
    input  wire logic [7:0] osc_wdata,
    input  wire logic       single_session_lock_cfg,
    output logic            route_write_lock,
    output logic            lock_once
);

    prm_key_e   key_q;
    logic       lock_q;
    logic       once_q;
    logic       one_way_q;

    // ***************************************************************
    // Key sequence
    // ***************************************************************
    // Any write that breaks the sequence starts it over
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            key_q <= KEY_IDLE;
        end else if (osc_wr) begin
            case (key_q)
                KEY_IDLE:  key_q <= (osc_wdata == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
                KEY_HALF:  key_q <= (osc_wdata == KEY_SECOND) ? KEY_ARMED : KEY_IDLE;
                KEY_ARMED: key_q <= KEY_IDLE;   // Single operation only
                default:   key_q <= KEY_IDLE;
            endcase
        end
    end

    // Configuration level is caught while reset is held
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            one_way_q <= single_session_lock_cfg;
        end
    end

    // ***************************************************************
    // Lock bit
    // ***************************************************************
    // The lock holds its state until the next armed write changes it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
            once_q <= 1'b0;
        end else if (osc_wr && key_q == KEY_ARMED) begin
            if (osc_wdata[LOCK_BIT]) begin
                lock_q <= 1'b1;
                once_q <= 1'b1;
            end else if (!(one_way_q && once_q)) begin
                lock_q <= 1'b0;
            end
        end
    end

    assign route_write_lock = lock_q;
    assign lock_once        = once_q;

    // ***************************************************************
    // Checks
    // ***************************************************************
    a_lock_needs_key: assert property (@(posedge core_clk) disable iff (!rst_n)
        (lock_q != $past(lock_q)) |-> ($past(key_q) == KEY_ARMED && $past(osc_wr)))
        else $error("Lock changed without the key sequence");

    a_one_way_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (one_way_q && once_q && lock_q) |=> lock_q [*3])
        else $error("Lock cleared in one-session mode");

endmodule

/* core/prm_remap_unit.sv */
// Peripheral remap unit: input and output routing matrix with lockable registers.
// Assumes peripheral and pin signals are synchronous to core_clk.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/10ps
module prm_remap_unit import prm_pkg::*; (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [DATA_W-1:0]    reg_rdata,
    input  wire logic                 single_session_lock_cfg,
    input  wire logic [PIN_COUNT-1:0] pin_in,
    input  wire logic [PIN_COUNT-1:0] pin_direction_regs,
    input  wire logic [PIN_COUNT-1:0] port_out,
    output logic      [PIN_COUNT-1:0] pin_out,
    output logic      [PIN_COUNT-1:0] pin_oe,
    input  wire logic                 uart1_transmit_out,
    input  wire logic                 uart1_request_to_send_out,
    input  wire logic                 spi1_serial_data_out,
    input  wire logic                 spi1_clock_out,
    input  wire logic                 spi1_select_out,
    input  wire logic                 compare_out_ch1,
    input  wire logic                 compare_out_ch2,
    output logic      [IN_COUNT-1:0]  periph_route_in,
    output logic                      cfg_mismatch_rst
);

    logic [SEL_W-1:0]  in_sel_q   [IN_COUNT];
    logic [SEL_W-1:0]  in_shd_q   [IN_COUNT];
    logic [SEL_W-1:0]  out_fn_q   [PIN_COUNT];
    logic [SEL_W-1:0]  out_shd_q  [PIN_COUNT];
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              mismatch_q;
    logic              route_write_lock;
    logic              lock_once;
    logic              osc_wr;
    logic              in_hit;
    logic              out_hit;
    logic [2:0]        in_idx;
    logic [4:0]        out_idx;
    logic [7:0]        out_off;
    logic [IN_COUNT-1:0]  in_diff;
    logic [PIN_COUNT-1:0] out_diff;
    logic [PIN_COUNT-1:0] pin_out_d;

    // ***************************************************************
    // Address decode
    // ***************************************************************
    // Word map, route fields in bits 4:0 of each 4-byte slot:
    //   IN_BASE + 4 * i   route word of peripheral input i, 0 to 7
    //   OUT_BASE + 4 * p  function word of pin p, 0 to 25
    //   OSC_ADDR          key target, lock in bit LOCK_BIT
    //   STAT_ADDR         lock, locked once, mismatch in bits 0 to 2
    // Misses and gaps decode to nothing: writes drop, reads give zero
    assign out_off = reg_addr - OUT_BASE;
    assign in_hit  = (reg_addr[7:5] == IN_BASE[7:5]) && (reg_addr[1:0] == 2'b00);
    assign out_hit = (reg_addr >= OUT_BASE) && (reg_addr < OUT_END)
                     && (reg_addr[1:0] == 2'b00);
    assign in_idx  = reg_addr[4:2];
    assign out_idx = out_off[6:2];
    assign osc_wr  = reg_wr && (reg_addr == OSC_ADDR);

    // ***************************************************************
    // Lock
    // ***************************************************************
    // Only writes to OSC_ADDR reach the key logic, so route traffic
    // between the keys never breaks a sequence
    prm_key_lock u_key_lock (
        .core_clk                (core_clk),
        .rst_n                   (rst_n),
        .osc_wr                  (osc_wr),
        .osc_wdata               (reg_wdata[7:0]),
        .single_session_lock_cfg (single_session_lock_cfg),
        .route_write_lock        (route_write_lock),
        .lock_once               (lock_once)
    );

    // ***************************************************************
    // Input routing, one field per peripheral input
    // ***************************************************************
    // The pin is read whatever its direction; software must set it as input
    for (genvar i = 0; i < IN_COUNT; i++) begin : g_in
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                in_sel_q[i] <= IN_SEL_RST;
                in_shd_q[i] <= IN_SEL_RST;
            end else if (reg_wr && in_hit && in_idx == i[2:0] && !route_write_lock) begin
                in_sel_q[i] <= reg_wdata[SEL_W-1:0];
                in_shd_q[i] <= reg_wdata[SEL_W-1:0];
            end
        end

        // Numbers at or past PIN_COUNT have no pin and read as low
        assign periph_route_in[i] = (in_sel_q[i] < PIN_COUNT[SEL_W-1:0])
                                    ? pin_in[in_sel_q[i]] : 1'b0;
        assign in_diff[i] = (in_sel_q[i] != in_shd_q[i]);

        // Route, lock and read-back checks for this input
        a_in_route: assert property (@(posedge core_clk) disable iff (!rst_n)
            periph_route_in[i] == ((in_sel_q[i] < 5'd26) ? pin_in[in_sel_q[i]] : 1'b0))
            else $error("Peripheral input not fed from selected pin");

        a_in_locked: assert property (@(posedge core_clk) disable iff (!rst_n)
            (route_write_lock && reg_wr && in_hit && in_idx == i[2:0])
            |=> $stable(in_sel_q[i]))
            else $error("Input field changed while locked");

        a_in_write: assert property (@(posedge core_clk) disable iff (!rst_n)
            (!route_write_lock && reg_wr && in_hit && in_idx == i[2:0])
            |=> (in_sel_q[i] == $past(reg_wdata[SEL_W-1:0])))
            else $error("Unlocked input field write lost");

        a_in_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
            !(reg_wr && in_hit && in_idx == i[2:0]) |=> $stable(in_sel_q[i]))
            else $error("Input field moved without a write");

        a_in_tied_low: assert property (@(posedge core_clk) disable iff (!rst_n)
            (in_sel_q[i] >= PIN_COUNT[SEL_W-1:0]) |-> !periph_route_in[i])
            else $error("Input without a pin not held low");

        a_in_read: assert property (@(posedge core_clk) disable iff (!rst_n)
            (reg_rd && in_hit && in_idx == i[2:0])
            |=> (reg_rdata == {11'h000, $past(in_sel_q[i])}))
            else $error("Input field read back wrong");
    end

    // ***************************************************************
    // Output routing, one field per pin
    // ***************************************************************
    // Kept apart from input routing so either side may move freely
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_out
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                out_fn_q[p]  <= OUT_FN_RST;
                out_shd_q[p] <= OUT_FN_RST;
            end else if (reg_wr && out_hit && out_idx == p[4:0] && !route_write_lock) begin
                out_fn_q[p]  <= reg_wdata[SEL_W-1:0];
                out_shd_q[p] <= reg_wdata[SEL_W-1:0];
            end
        end

        // Function select; codes with no function fall back to the port
        always_comb begin
            case (out_fn_q[p])
                FN_U1_TX:   pin_out_d[p] = uart1_transmit_out;
                FN_U1_RTS:  pin_out_d[p] = uart1_request_to_send_out;
                FN_SPI_DO:  pin_out_d[p] = spi1_serial_data_out;
                FN_SPI_CLK: pin_out_d[p] = spi1_clock_out;
                FN_SPI_SEL: pin_out_d[p] = spi1_select_out;
                FN_CMP1:    pin_out_d[p] = compare_out_ch1;
                FN_CMP2:    pin_out_d[p] = compare_out_ch2;
                FN_PORT:    pin_out_d[p] = port_out[p];
                default:    pin_out_d[p] = port_out[p];
            endcase
        end

        // Direction stays with the port direction bit, 1 means input
        assign pin_oe[p]   = !pin_direction_regs[p];
        assign out_diff[p] = (out_fn_q[p] != out_shd_q[p]);

        // One check per assigned code, then the fallback, lock and read-back
        a_out_uart: assert property (@(posedge core_clk) disable iff (!rst_n)
            (out_fn_q[p] == 5'h03) |-> (pin_out[p] == uart1_transmit_out))
            else $error("Code 3 pin not driven by uart transmit");

        a_out_rts: assert property (@(posedge core_clk) disable iff (!rst_n)
            (out_fn_q[p] == 5'h04) |-> (pin_out[p] == uart1_request_to_send_out))
            else $error("Code 4 pin not driven by uart rts");

        a_out_spi_data: assert property (@(posedge core_clk) disable iff (!rst_n)
            (out_fn_q[p] == 5'h07) |-> (pin_out[p] == spi1_serial_data_out))
            else $error("Code 7 pin not driven by spi data");

        a_out_spi_clk: assert property (@(posedge core_clk) disable iff (!rst_n)
            (out_fn_q[p] == 5'h08) |-> (pin_out[p] == spi1_clock_out))
            else $error("Code 8 pin not driven by spi clock");

        a_out_spi_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
            (out_fn_q[p] == 5'h09) |-> (pin_out[p] == spi1_select_out))
            else $error("Code 9 pin not driven by spi select");

        a_out_cmp1: assert property (@(posedge core_clk) disable iff (!rst_n)
            (out_fn_q[p] == 5'h12) |-> (pin_out[p] == compare_out_ch1))
            else $error("Code 18 pin not driven by compare channel 1");

        a_out_compare: assert property (@(posedge core_clk) disable iff (!rst_n)
            (out_fn_q[p] == 5'h13) |-> (pin_out[p] == compare_out_ch2))
            else $error("Code 19 pin not driven by compare channel 2");

        a_out_port_code: assert property (@(posedge core_clk) disable iff (!rst_n)
            (out_fn_q[p] == 5'h00 || out_fn_q[p] == 5'h1f) |-> (pin_out[p] == port_out[p]))
            else $error("Port code pin not driven by port logic");

        a_out_write: assert property (@(posedge core_clk) disable iff (!rst_n)
            (!route_write_lock && reg_wr && out_hit && out_idx == p[4:0])
            |=> (out_fn_q[p] == $past(reg_wdata[4:0])))
            else $error("Unlocked output field write lost");

        a_out_locked: assert property (@(posedge core_clk) disable iff (!rst_n)
            (route_write_lock && reg_wr && out_hit && out_idx == p[4:0])
            |=> $stable(out_fn_q[p]))
            else $error("Output field changed while locked");

        a_out_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
            !(reg_wr && out_hit && out_idx == p[4:0]) |=> $stable(out_fn_q[p]))
            else $error("Output field moved without a write");

        a_out_read: assert property (@(posedge core_clk) disable iff (!rst_n)
            (reg_rd && out_hit && out_idx == p[4:0])
            |=> (reg_rdata == {11'h000, $past(out_fn_q[p])}))
            else $error("Output field read back wrong");
    end

    // Zero latency from peripheral to pin; a code change may glitch the pin
    // for part of a cycle, so move codes while the peripheral is idle
    assign pin_out = pin_out_d;

    // ***************************************************************
    // Shadow monitor
    // ***************************************************************
    // Catches upsets in the route cells; raises a reset request one cycle later that stands while the copies differ
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mismatch_q <= 1'b0;
        end else begin
            mismatch_q <= (|in_diff) || (|out_diff);
        end
    end

    assign cfg_mismatch_rst = mismatch_q;

    a_shadow_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        (in_diff == '0 && out_diff == '0) |=> !cfg_mismatch_rst)
        else $error("Mismatch reset without a difference");

    // Both copies take the same write, so an upset that strikes both alike
    // goes unseen; that is the price of a plain copy instead of a code
    a_shadow_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        (in_diff != '0 || out_diff != '0) |=> cfg_mismatch_rst)
        else $error("Difference without a mismatch reset");

    // ***************************************************************
    // Read path
    // ***************************************************************
    // Data stand one cycle after the strobe; unmapped addresses read zero
    always_comb begin
        rdata_d = '0;
        if (in_hit) begin
            rdata_d[SEL_W-1:0] = in_sel_q[in_idx];
        end else if (out_hit) begin
            rdata_d[SEL_W-1:0] = out_fn_q[out_idx];
        end else if (reg_addr == OSC_ADDR) begin
            rdata_d[LOCK_BIT] = route_write_lock;
        end else if (reg_addr == STAT_ADDR) begin
            rdata_d[0] = route_write_lock;
            rdata_d[1] = lock_once;
            rdata_d[2] = mismatch_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;

    // Data are zero outside the answer cycle, so a stale word is never taken
    a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !reg_rd |=> (reg_rdata == '0))
        else $error("Read data stand outside the answer cycle");

    a_rdata_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == OSC_ADDR)
        |=> (reg_rdata[LOCK_BIT] == $past(route_write_lock)))
        else $error("Lock bit read back wrong");

    a_rdata_once: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == STAT_ADDR)
        |=> (reg_rdata[1] == $past(lock_once)))
        else $error("Locked-once bit read back wrong");

endmodule

/* testbench/prm_periph_model.sv */
// Behavioural model of the peripherals and pin pads around the remap unit.
// Assumes one core clock; all outputs move just after each rising edge.
`timescale 1ns/10ps
module prm_periph_model import prm_pkg::*; (
    input  wire logic                 core_clk,
    output logic      [PIN_COUNT-1:0] pin_in,
    output logic      [6:0]           periph_out
);
    // ***************************************************************
    // Pattern source
    // ***************************************************************
    logic [31:0] cnt_q = 32'h1234_5677;

    // Odd step keeps every bit moving, so a stuck or crossed route cannot hide
    always_ff @(posedge core_clk) begin
        cnt_q <= cnt_q + 32'h9e37_79b9;
    end

    // Pads and peripheral outputs both change every cycle
    assign pin_in     = cnt_q[25:0] ^ cnt_q[31:6];
    assign periph_out = cnt_q[31:25];  // tx, rts, sdo, sck, ss, cmp1, cmp2
endmodule

/* testbench/tb_prm_remap_unit.sv */
// Self-checking bench for the pin remap unit, driven through its register port.
// Assumes the peripheral model in prm_periph_model and the register map of prm_pkg.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_prm_remap_unit import prm_pkg::*;;
    // ***************************************************************
    // Signals
    // ***************************************************************
    logic                 core_clk = 1'b0;
    logic                 rst_n    = 1'b0;
    logic [ADDR_W-1:0]    reg_addr = '0;
    logic [DATA_W-1:0]    reg_wdata = '0;
    logic                 reg_wr   = 1'b0;
    logic                 reg_rd   = 1'b0;
    logic [DATA_W-1:0]    reg_rdata;
    logic                 one_way  = 1'b0;
    logic [PIN_COUNT-1:0] pin_in;
    logic [PIN_COUNT-1:0] dir      = 26'h3f9_f4ff;  // Routed inputs set as inputs
    logic [PIN_COUNT-1:0] port_out = 26'h155_5555;
    logic [PIN_COUNT-1:0] pin_out;
    logic [PIN_COUNT-1:0] pin_oe;
    logic [6:0]           po;
    logic [IN_COUNT-1:0]  route_in;
    logic                 mism;
    logic                 mism_seen = 1'b0;
    logic [15:0]          d;
    logic [4:0]           sel [IN_COUNT];
    logic [4:0]           codes [10] = '{5'h00, 5'h03, 5'h04, 5'h07, 5'h08, 5'h09,
                                         5'h12, 5'h13, 5'h05, 5'h1f};
    int                   failures = 0;
    int                   n_tests  = 0;

    always #2 core_clk = ~core_clk;

    // Port data keeps toggling so the ordinary path is really observed
    always @(posedge core_clk) port_out <= ~port_out;

    // A mismatch pulse in normal use is an error at any time
    always @(posedge core_clk) if (rst_n && mism !== 1'b0) mism_seen <= 1'b1;

    prm_periph_model prm_periph_model_i (
        .core_clk   (core_clk),
        .pin_in     (pin_in),
        .periph_out (po)
    );

    prm_remap_unit prm_remap_unit_i (
        .core_clk                  (core_clk),
        .rst_n                     (rst_n),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_wr                    (reg_wr),
        .reg_rd                    (reg_rd),
        .reg_rdata                 (reg_rdata),
        .single_session_lock_cfg   (one_way),
        .pin_in                    (pin_in),
        .pin_direction_regs        (dir),
        .port_out                  (port_out),
        .pin_out                   (pin_out),
        .pin_oe                    (pin_oe),
        .uart1_transmit_out        (po[0]),
        .uart1_request_to_send_out (po[1]),
        .spi1_serial_data_out      (po[2]),
        .spi1_clock_out            (po[3]),
        .spi1_select_out           (po[4]),
        .compare_out_ch1           (po[5]),
        .compare_out_ch2           (po[6]),
        .periph_route_in           (route_in),
        .cfg_mismatch_rst          (mism)
    );

    // ***************************************************************
    // Access tasks
    // ***************************************************************
    task automatic do_reset(input int n);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (n) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic keys(input logic [15:0] last);
        wr(OSC_ADDR, {8'h00, KEY_FIRST});
        wr(OSC_ADDR, {8'h00, KEY_SECOND});
        wr(OSC_ADDR, last);
    endtask

    // Expected pin level, worked out from the function code table
    function automatic logic exp_pin(input logic [4:0] c, input int p);
        case (c)
            5'h03:   return po[0];
            5'h04:   return po[1];
            5'h07:   return po[2];
            5'h08:   return po[3];
            5'h09:   return po[4];
            5'h12:   return po[5];
            5'h13:   return po[6];
            default: return port_out[p];
        endcase
    endfunction

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard: far beyond the length of the sequence below
    initial begin
        #80000;
        failures++;
        results();
    end

    // ***************************************************************
    // Main sequence
    // ***************************************************************
    initial begin
        do_reset(20);
        rd(IN_BASE, d);
        `CHK("in_sel_rst", 16'h001f, d)
        rd(OUT_BASE, d);
        `CHK("out_fn_rst", 16'h0000, d)
        `CHK("route_rst", 8'h00, route_in)
        `CHK("pin_port", port_out, pin_out)
        `CHK("pin_oe", ~dir, pin_oe)
        rd(8'hfc, d);
        `CHK("unmapped", 16'h0000, d)
        // Input routes: spread pins, the top pin and one past the end
        for (int i = 0; i < IN_COUNT; i++) begin
            sel[i] = (i == 6) ? 5'd25 : (i == 7) ? 5'd26 : 5'(i * 3 + 4);
            wr(8'(IN_BASE + 4 * i), {11'h000, sel[i]});
        end
        // Output codes on distinct pins, including unassigned codes
        for (int k = 0; k < 10; k++) begin
            wr(8'(OUT_BASE + 4 * (k * 2 + 3)), {11'h000, codes[k]});
            rd(8'(OUT_BASE + 4 * (k * 2 + 3)), d);
            `CHK("out_read", {11'h000, codes[k]}, d)
            repeat (2) begin
                `CHK("pin_out", exp_pin(codes[k], k * 2 + 3), pin_out[k * 2 + 3])
                @(posedge core_clk);
                #1;
            end
        end
        `CHK("oe_kept", ~dir, pin_oe)
        // Input routes still hold after output programming
        for (int i = 0; i < IN_COUNT; i++) begin
            rd(8'(IN_BASE + 4 * i), d);
            `CHK("in_read", {11'h000, sel[i]}, d)
            `CHK("route_in", (sel[i] < 26) ? pin_in[sel[i]] : 1'b0, route_in[i])
        end
        // Lock, then writes must leave routes untouched
        keys(16'h0040);
        rd(OSC_ADDR, d);
        `CHK("lock_set", 16'h0040, d)
        wr(IN_BASE, 16'h0002);
        wr(8'(OUT_BASE + 4 * 5), 16'h0000);
        rd(IN_BASE, d);
        `CHK("locked_in", {11'h000, sel[0]}, d)
        rd(8'(OUT_BASE + 4 * 5), d);
        `CHK("locked_out", 16'h0003, d)
        // Broken key sequence gives no credit
        wr(OSC_ADDR, 16'h0046);
        wr(OSC_ADDR, 16'h0012);
        wr(OSC_ADDR, 16'h0057);
        wr(OSC_ADDR, 16'h0000);
        rd(OSC_ADDR, d);
        `CHK("bad_keys", 16'h0040, d)
        keys(16'h0000);
        rd(OSC_ADDR, d);
        `CHK("lock_clear", 16'h0000, d)
        wr(IN_BASE, 16'h0009);
        rd(IN_BASE, d);
        `CHK("rewrite", 16'h0009, d)
        // One-way configuration: a set lock cannot be cleared
        @(posedge core_clk) one_way <= 1'b1;
        do_reset(2);
        keys(16'h0040);
        keys(16'h0000);
        rd(OSC_ADDR, d);
        `CHK("one_way", 16'h0040, d)
        rd(STAT_ADDR, d);
        `CHK("stat_once", 16'h0003, d)
        @(posedge core_clk) one_way <= 1'b0;
        do_reset(2);
        keys(16'h0040);
        keys(16'h0000);
        rd(OSC_ADDR, d);
        `CHK("many_way", 16'h0000, d)
        rd(STAT_ADDR, d);
        `CHK("stat_open", 16'h0002, d)
        `CHK("mismatch", 1'b0, mism_seen)
        results();
    end
endmodule
